/* design/hpio_top.sv */
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
// port conditioning, direction control and pulse regeneration
module hpio_top #(
  parameter int unsigned EOD_BITS = hpio_pkg::EOD_BITS,
  parameter int unsigned BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // receive pins
  input wire logic [1:0] group_a_rx_in,
  input wire logic [1:0] group_b_rx_in,
  input wire logic fifth_port_rx_in,
  // polarity and style straps
  input wire logic group_a_rx_invert,
  input wire logic group_b_rx_invert,
  input wire logic ext_rx_invert,
  input wire logic group_a_tx_active_high,
  input wire logic group_b_tx_active_high,
  input wire logic ext_tx_active_high,
  input wire logic group_a_tx_style,
  input wire logic group_b_tx_style,
  input wire logic ext_tx_style,
  // jitter, noise and expansion straps
  input wire logic group_a_noise_cut_n,
  input wire logic group_b_noise_cut_n,
  input wire logic ext_noise_cut_n,
  input wire logic group_a_big_jitter_n,
  input wire logic group_b_big_jitter_n,
  input wire logic ext_big_jitter_n,
  input wire logic cascade_open_drain_n,
  input wire logic [2:0] rate_code,
  // transmit pins
  output logic [1:0] group_a_tx_out,
  output logic [1:0] group_b_tx_out,
  output logic fifth_port_tx_out,
  output logic fifth_port_tx_oe,
  output logic [1:0] dipulse_tx_pulse_n,
  output logic backplane_tx_pulse_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int unsigned NP = hpio_pkg::NPORT;
  localparam int unsigned SW = 24;

  // silence counter is 16 bits wide
  if (EOD_BITS < 2 || EOD_BITS > 200) begin : g_bad_eod
    $error("hpio_top: EOD_BITS out of range 2..200");
  end

  // port index to strap group: 0 group a, 1 group b, 2 fifth
  function automatic logic [1:0] grp_of(input logic [2:0] p);
    logic [1:0] g;
    g = (p < 3'h2) ? 2'h0 : ((p < 3'h4) ? 2'h1 : 2'h2);
    return g;
  endfunction

  // lowest active port wins a simultaneous start
  function automatic logic [2:0] first_of(input logic [NP-1:0] v);
    logic [2:0] f;
    f = 3'h0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) begin
        f = 3'(i);
      end
    end
    return f;
  endfunction

  // clock cycles in one bit time for a rate code
  function automatic logic [8:0] bit_cyc(input logic [2:0] c);
    logic [8:0] n;
    case (c)
      hpio_pkg::RATE_5M: n = 9'(hpio_pkg::BIT_CYC_REF / 2);
      hpio_pkg::RATE_10M: n = 9'(hpio_pkg::BIT_CYC_REF / 4);
      hpio_pkg::RATE_RSVD: n = 9'(hpio_pkg::BIT_CYC_REF);
      default: n = 9'(hpio_pkg::BIT_CYC_REF) << (3'h4 - c);
    endcase
    return n;
  endfunction

  // ---- pin synchronisation
  logic [SW-1:0] pin_raw; // all pins in one vector
  logic [SW-1:0] pin_s; // synchronised copy
  logic [NP-1:0] rx_s; // a0 a1 b0 b1 fifth
  logic [2:0] rx_inv_s; // per group, bit 0 group a
  logic [2:0] tx_hi_s;
  logic [2:0] style_s;
  logic [2:0] nc_n_s;
  logic [2:0] bj_n_s;
  logic od_n_s;
  logic [2:0] rate_s;

  assign pin_raw = {rate_code, cascade_open_drain_n,
    ext_big_jitter_n, group_b_big_jitter_n, group_a_big_jitter_n,
    ext_noise_cut_n, group_b_noise_cut_n, group_a_noise_cut_n,
    ext_tx_style, group_b_tx_style, group_a_tx_style,
    ext_tx_active_high, group_b_tx_active_high, group_a_tx_active_high,
    ext_rx_invert, group_b_rx_invert, group_a_rx_invert,
    fifth_port_rx_in, group_b_rx_in, group_a_rx_in};

  hpio_sync #(.W(SW)) u_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(pin_s)
  );

  assign rx_s = pin_s[4:0];
  assign rx_inv_s = pin_s[7:5];
  assign tx_hi_s = pin_s[10:8];
  assign style_s = pin_s[13:11];
  assign nc_n_s = pin_s[16:14];
  assign bj_n_s = pin_s[19:17];
  assign od_n_s = pin_s[20];
  assign rate_s = pin_s[23:21];

  // ---- state
  hpio_pkg::hpio_dir_t dir_r; // direction state
  hpio_pkg::hpio_dir_t dir_nxt;
  logic [2:0] port_r; // receiving port
  logic [2:0] rate_r; // rate frozen for the frame
  logic [NP-1:0] act_prev_r; // last normalised level
  logic [8:0] db_r; // dead band remaining
  logic run_r; // slot timing locked to reference
  logic [8:0] ph_r; // phase inside receive slot
  logic seen_r; // pulse seen in current slot
  logic [15:0] eod_r; // cycles since last pulse
  logic pend_v_r; // slot waiting for the buffer
  logic pend_d_r;
  logic [8:0] tph_r; // transmit phase
  logic cur_r; // slot being transmitted
  logic inhibit_r; // software transmit inhibit

  // ---- receive conditioning
  logic [NP-1:0] act; // receive level, 1 means pulse
  logic [NP-1:0] rise; // leading edge per port
  logic [8:0] bit_w;
  logic [8:0] half_w;
  logic rate_ok;
  logic nc_on;
  logic pulse_ok;
  logic start;
  logic ref_first;
  logic slot_end;
  logic [15:0] eod_lim;

  for (genvar p = 0; p < NP; p++) begin : g_rx
    assign act[p] = rx_s[p] ^ rx_inv_s[grp_of(3'(p))];
    assign rise[p] = act[p] & ~act_prev_r[p];
  end

  assign bit_w = bit_cyc(rate_r);
  assign rate_ok = (rate_s != hpio_pkg::RATE_RSVD);
  assign half_w = bit_w >> 1;
  assign eod_lim = 16'(EOD_BITS * bit_w);

  // blanking only with noise cut on
  assign nc_on = ~nc_n_s[grp_of(port_r)];
  assign pulse_ok = (dir_r == hpio_pkg::HPIO_LOCK) & rise[port_r] & (db_r == '0);

  // any leading edge while idle takes direction, unless the rate is reserved or transmit is inhibited
  assign start = (dir_r == hpio_pkg::HPIO_IDLE) & (|rise) & rate_ok & ~inhibit_r;
  // normal mode takes phase from the first pulse
  assign ref_first = bj_n_s[grp_of(first_of(rise))];
  assign slot_end = run_r & (ph_r == bit_w - 9'h001);

  // ---- slot buffer
  hpio_stream_if #(.W(1)) up_s ();
  hpio_stream_if #(.W(1)) dn_s ();
  logic tx_tick;

  assign up_s.valid = pend_v_r;
  assign up_s.data = pend_d_r;
  // drain only at bit boundaries; a shorter bit after a rate change never strands the phase
  assign tx_tick = (tph_r >= bit_w - 9'h001);
  assign dn_s.ready = tx_tick;

  hpio_buf2 #(.W(1), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_s(up_s),
    .out_s(dn_s)
  );

  // ---- direction machine
  always_comb begin
    dir_nxt = dir_r;
    unique case (dir_r)
      hpio_pkg::HPIO_IDLE: begin
        if (start) begin
          dir_nxt = hpio_pkg::HPIO_LOCK;
        end
      end
      hpio_pkg::HPIO_LOCK: begin
        if (eod_r >= eod_lim || inhibit_r) begin
          dir_nxt = hpio_pkg::HPIO_DRAIN;
        end
      end
      hpio_pkg::HPIO_DRAIN: begin
        // let buffered slots leave before turning round
        if (!pend_v_r && !dn_s.valid && tx_tick) begin
          dir_nxt = hpio_pkg::HPIO_IDLE;
        end
      end
      default: dir_nxt = hpio_pkg::HPIO_IDLE;
    endcase
  end

  // direction, port and rate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= hpio_pkg::HPIO_IDLE;
      port_r <= 3'h0;
      rate_r <= hpio_pkg::RATE_2M5;
      act_prev_r <= '0;
    end else begin
      dir_r <= dir_nxt;
      act_prev_r <= act;
      if (dir_r == hpio_pkg::HPIO_IDLE) begin
        rate_r <= rate_s;
      end
      if (start) begin
        port_r <= first_of(rise);
      end
    end
  end

  // dead band and silence timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      db_r <= 9'h000;
      eod_r <= 16'h0000;
    end else begin
      // dead band of half a bit after each pulse
      // the edge that takes direction arms the band too, so its ringing is cut
      if ((pulse_ok && nc_on) || (start && !nc_n_s[grp_of(first_of(rise))])) begin
        db_r <= half_w;
      end else if (db_r != 9'h000) begin
        db_r <= db_r - 9'h001;
      end
      if (start || pulse_ok || dir_r != hpio_pkg::HPIO_LOCK) begin
        eod_r <= 16'h0000;
      end else begin
        eod_r <= eod_r + 16'h0001;
      end
    end
  end

  // slot timing: each slot is centred on the reference pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      ph_r <= 9'h000;
      seen_r <= 1'b0;
    end else if (dir_r == hpio_pkg::HPIO_DRAIN) begin
      run_r <= 1'b0;
      seen_r <= 1'b0;
    end else if ((start && ref_first) || (pulse_ok && !run_r)) begin
      run_r <= 1'b1;
      ph_r <= half_w;
      seen_r <= 1'b1;
    end else if (slot_end) begin
      ph_r <= 9'h000;
      seen_r <= pulse_ok;
    end else if (run_r) begin
      ph_r <= ph_r + 9'h001;
      seen_r <= seen_r | pulse_ok;
    end
  end

  // pending slot holds until the buffer takes it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_v_r <= 1'b0;
      pend_d_r <= 1'b0;
    end else if (slot_end && (!pend_v_r || up_s.ready)) begin
      pend_v_r <= 1'b1;
      pend_d_r <= seen_r;
    end else if (up_s.ready) begin
      pend_v_r <= 1'b0;
    end
  end

  // ---- transmit regeneration
  logic pulse1_w; // first half of a one slot
  logic pulse2_w; // second half of a one slot
  logic [NP-1:0] en_w; // per-port transmit enable
  logic [NP-1:0] asrt_w; // asserted before polarity
  logic [NP-1:0] lvl_w; // pin level after polarity
  logic ext_out_nxt;
  logic ext_oe_nxt;

  assign pulse1_w = cur_r & (tph_r < half_w);
  assign pulse2_w = cur_r & (tph_r >= half_w);

  for (genvar p = 0; p < NP; p++) begin : g_tx
    // all but the receiving port transmit
    assign en_w[p] = (dir_r != hpio_pkg::HPIO_IDLE) & (port_r != 3'(p)) & ~inhibit_r;
    // enable level or pulse gated by enable
    assign asrt_w[p] = style_s[grp_of(3'(p))] ? en_w[p] : (en_w[p] & pulse1_w);
    assign lvl_w[p] = tx_hi_s[grp_of(3'(p))] ? asrt_w[p] : ~asrt_w[p];
  end

  assign ext_out_nxt = od_n_s ? lvl_w[4] : 1'b0;
  assign ext_oe_nxt = od_n_s ? 1'b1 : ~lvl_w[4];

  // transmit phase and current slot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tph_r <= 9'h000;
      cur_r <= 1'b0;
    end else begin
      tph_r <= tx_tick ? 9'h000 : tph_r + 9'h001;
      if (tx_tick) begin
        cur_r <= dn_s.valid & dn_s.data;
      end
    end
  end

  // all pins from flops; transmit levels reset low, pulse pins high, fifth port released
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_a_tx_out <= 2'h0;
      group_b_tx_out <= 2'h0;
      fifth_port_tx_out <= 1'b0;
      fifth_port_tx_oe <= 1'b0;
      dipulse_tx_pulse_n <= 2'h3;
      backplane_tx_pulse_n <= 1'b1;
    end else begin
      group_a_tx_out <= lvl_w[1:0];
      group_b_tx_out <= lvl_w[3:2];
      fifth_port_tx_out <= ext_out_nxt;
      fifth_port_tx_oe <= ext_oe_nxt;
      dipulse_tx_pulse_n <= ~{pulse2_w, pulse1_w};
      backplane_tx_pulse_n <= ~pulse1_w;
    end
  end

  // ---- register slave
  logic req; // read or write presented
  logic [31:0] status_w; // live state for software
  logic [31:0] rd_word; // decoded read data

  assign req = avs_read | avs_write;
  assign status_w = {19'h0_0000, act, rate_s == hpio_pkg::RATE_RSVD,
    rate_r, port_r, dir_r != hpio_pkg::HPIO_IDLE};
  assign rd_word = (avs_address == hpio_pkg::REG_CTRL) ? {31'h0000_0000, inhibit_r} :
    (avs_address == hpio_pkg::REG_STATUS) ? status_w : 32'h0000_0000;

  // one wait state per access; unmapped reads return zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      inhibit_r <= hpio_pkg::CTRL_INHIBIT_RST;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= rd_word;
      end
      // write lands at the edge after the wait ends, while waitrequest is low
      if (avs_write && !avs_waitrequest && avs_address == hpio_pkg::REG_CTRL) begin
        inhibit_r <= avs_writedata[hpio_pkg::CTRL_INHIBIT_BIT];
      end
    end
  end
endmodule

/* design/hpio_pkg.sv */
// Contract
// - receive polarity strap: 0 high, 1 low
// - transmit polarity strap: 0 low, 1 high
// - style strap 1 gives transmit-enable level
// - pulse style: pulse gated by enable
// - two dipulse outputs, always active low
// - backplane pulse output, always active low
// - big jitter: second pulse sets phase
// - expansion strap 0: open drain fifth port
// - noise cut strap 0 applies dead band
// - reset disables transmit; activity locks direction (reset drives group a/b transmit pins low, asserted for polarity strap 0)
// - silence for end-of-data time releases direction
package hpio_pkg;
  // clock and reference rate
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned REF_BPS = 2_500_000;
  // cycles per bit at the reference rate
  localparam int unsigned BIT_CYC_REF = CLK_HZ / REF_BPS;
  // end-of-data silence at the reference rate, in ns
  localparam int unsigned EOD_NS = 5600;
  localparam int unsigned EOD_CYC_REF = EOD_NS / CLK_NS;
  // the silence scales with the bit time, so keep it in bits
  localparam int unsigned EOD_BITS = EOD_CYC_REF / BIT_CYC_REF;
  // five ports: a0, a1, b0, b1, fifth
  localparam int unsigned NPORT = 5;
  // rate strap codes
  localparam logic [2:0] RATE_2M5 = 3'h4;
  localparam logic [2:0] RATE_5M = 3'h5;
  localparam logic [2:0] RATE_RSVD = 3'h6;
  localparam logic [2:0] RATE_10M = 3'h7;
  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // control fields and reset value
  localparam int unsigned CTRL_INHIBIT_BIT = 0;
  localparam logic CTRL_INHIBIT_RST = 1'h0;
  // status fields
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_PORT_LSB = 1;
  localparam int unsigned ST_RATE_LSB = 4;
  localparam int unsigned ST_RSVD_BIT = 7;
  localparam int unsigned ST_ACT_LSB = 8;
  // direction states, gray along idle-lock-drain
  typedef enum logic [1:0] {
    HPIO_IDLE = 2'h0,
    HPIO_LOCK = 2'h1,
    HPIO_DRAIN = 2'h3
  } hpio_dir_t;
endpackage

/* design/hpio_stream_if.sv */
`timescale 1ns/100ps
// one-bit-slot stream between recovery and transmitter
interface hpio_stream_if #(parameter int unsigned W = 1);
  logic valid; // word offered
  logic ready; // word accepted
  logic [W-1:0] data; // slot content
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

/* design/hpio_sync.sv */
`timescale 1ns/100ps
// two-stage synchroniser for pin-level inputs
module hpio_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // first stage feeds only the second
  logic [W-1:0] meta_r;

  // both stages clear to zero; straps settle two edges later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* design/hpio_buf2.sv */
`timescale 1ns/100ps
// small slot buffer; absorbs phase drift between recovery and transmit
module hpio_buf2 #(
  parameter int unsigned W = 1,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  hpio_stream_if.snk in_s,
  // draining side
  hpio_stream_if.src out_s
);
  localparam int unsigned AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = AW + 1;

  // pointers wrap naturally, so depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("hpio_buf2: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem_r [DEPTH]; // storage flops
  logic [AW-1:0] wr_r; // next write slot
  logic [AW-1:0] rd_r; // next read slot
  logic [CW-1:0] cnt_r; // words held
  logic [CW-1:0] cnt_nxt;
  logic push;
  logic pop;
  logic full;
  logic empty;

  // honest flags straight from the count
  assign full = (cnt_r == CW'(DEPTH));
  assign empty = (cnt_r == '0);
  assign in_s.ready = ~full;
  assign out_s.valid = ~empty;
  assign out_s.data = mem_r[rd_r];
  assign push = in_s.valid & ~full;
  assign pop = out_s.ready & ~empty;
  assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);

  // data path needs no reset; valid guards it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_s.data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_r + AW'(push);
      rd_r <= rd_r + AW'(pop);
      cnt_r <= cnt_nxt;
    end
  end
endmodule

/* test/hpio_props.sv */
`timescale 1ns/100ps
// pin-level checks on the hub top
module hpio_props #(
  parameter int unsigned EOD_BITS = hpio_pkg::EOD_BITS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // receive pins and expansion strap
  input wire logic [1:0] group_a_rx_in,
  input wire logic [1:0] group_b_rx_in,
  input wire logic fifth_port_rx_in,
  input wire logic cascade_open_drain_n,
  // transmit pins
  input wire logic fifth_port_tx_out,
  input wire logic fifth_port_tx_oe,
  input wire logic [1:0] dipulse_tx_pulse_n,
  input wire logic backplane_tx_pulse_n,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // slowest bit is 320 cycles; allow drain and margin
  localparam int unsigned QUIET_MAX = (EOD_BITS + 4) * 320;
  wire logic [4:0] rx_now = {fifth_port_rx_in, group_b_rx_in, group_a_rx_in};
  logic [4:0] rx_last_r; // pins one cycle ago
  logic [15:0] quiet_r; // cycles since a pin moved
  logic [2:0] od_hist_r; // strap history, covers the synchroniser
  wire logic [15:0] quiet_nxt = (rx_now != rx_last_r) ? 16'h0000 :
    (quiet_r == 16'(QUIET_MAX)) ? quiet_r : quiet_r + 16'h0001;
  // saturating silence counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_last_r <= 5'h00;
      quiet_r <= 16'h0000;
      od_hist_r <= 3'h7;
    end else begin
      rx_last_r <= rx_now;
      quiet_r <= quiet_nxt;
      od_hist_r <= {od_hist_r[1:0], cascade_open_drain_n};
    end
  end
  // first half of a slot ends, first half of a slot begins
  sequence first_half_end;
    $rose(dipulse_tx_pulse_n[0]);
  endsequence
  sequence first_half_start;
    $fell(dipulse_tx_pulse_n[0]);
  endsequence
  pulse_copy_a: assert property (backplane_tx_pulse_n == dipulse_tx_pulse_n[0])
    else $error("backplane pulse differs");
  pulse_apart_a: assert property (dipulse_tx_pulse_n != 2'h0)
    else $error("both dipulse halves low");
  half_order_a: assert property (first_half_end |-> !dipulse_tx_pulse_n[1])
    else $error("second half missing");
  pulse_width_a: assert property (first_half_start |=> !dipulse_tx_pulse_n[0])
    else $error("pulse too short");
  quiet_idle_a: assert property (quiet_r == 16'(QUIET_MAX) |-> dipulse_tx_pulse_n == 2'h3)
    else $error("pulses after silence");
  od_drive_a: assert property ((od_hist_r == 3'h0) && fifth_port_tx_oe |-> !fifth_port_tx_out)
    else $error("open drain drives high");
  reset_calm_a: assert property ($rose(rst_n) |-> (dipulse_tx_pulse_n == 2'h3) [*4])
    else $error("pulse right after reset");
  // bus handshake
  wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
endmodule
bind hpio_top hpio_props #(.EOD_BITS(EOD_BITS)) hpio_props_inst (
  .sys_clk, .rst_n, .group_a_rx_in, .group_b_rx_in, .fifth_port_rx_in,
  .cascade_open_drain_n, .fifth_port_tx_out, .fifth_port_tx_oe,
  .dipulse_tx_pulse_n, .backplane_tx_pulse_n, .avs_read, .avs_write, .avs_waitrequest
);

/* test/hpio_media_model.sv */
`timescale 1ns/100ps
// far-side transceivers: one half-bit pulse per '1' slot
module hpio_media_model (
  // clock
  input wire logic sys_clk,
  // idle level follows the receive polarity strap
  input wire logic idle_lvl,
  // receive pins toward the hub
  output logic [4:0] rx_pin
);
  logic [4:0] act_r = 5'h00; // pulse asserted per port
  // inactive pins sit at the deasserted level, never floating
  assign rx_pin = act_r ^ {5{idle_lvl}};
  // gl adds leading-edge ringing inside each pulse
  task automatic send(input int p, input int n, input int bc, input int gl);
    for (int k = 0; k < n; k++) begin
      for (int c = 0; c < bc; c++) begin
        act_r[p] <= (c < bc / 2) && !(gl != 0 && c == 1);
        @(posedge sys_clk);
      end
    end
  endtask
endmodule

/* test/hub_port_io_config_tb_top.sv */
`timescale 1ns/100ps
// self-checking bench for the hub port conditioning
module hub_port_io_config_tb_top;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  // one strap set shared by all groups
  logic inv = 1'h0, ah = 1'h1, sty = 1'h0, nc_n = 1'h1, jit_n = 1'h1, od_n = 1'h1;
  logic [2:0] rate = 3'h4, row_port = 3'h0;
  // register bus
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0, avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic avs_waitrequest, fifth_port_tx_oe, backplane_tx_pulse_n;
  logic [1:0] dipulse_tx_pulse_n;
  wire logic [4:0] rx, tx_all;
  // open drain fifth port is not compared as a level
  wire logic [4:0] mask = od_n ? 5'h1f : 5'h0f;
  int failures = 0, comparisons = 0, falls = 0;
  // rows: rate[9:7] port[6:4] rx invert, tx active high, style, jitter_n
  logic [9:0] rows [8] = '{10'h005, 10'h09b, 10'h120, 10'h1be,
                           10'h247, 10'h28d, 10'h3a2, 10'h3c9};
  always #10 sys_clk = ~sys_clk;
  // regenerated pulses counted at their leading edge
  always @(negedge dipulse_tx_pulse_n[0]) falls++;
  hpio_media_model hpio_media_model_inst (.sys_clk, .idle_lvl(inv), .rx_pin(rx));
  hpio_top #(.EOD_BITS(4)) hpio_top_inst (
    .sys_clk, .rst_n,
    .group_a_rx_in(rx[1:0]), .group_b_rx_in(rx[3:2]), .fifth_port_rx_in(rx[4]),
    .group_a_rx_invert(inv), .group_b_rx_invert(inv), .ext_rx_invert(inv),
    .group_a_tx_active_high(ah), .group_b_tx_active_high(ah), .ext_tx_active_high(ah),
    .group_a_tx_style(sty), .group_b_tx_style(sty), .ext_tx_style(sty),
    .group_a_noise_cut_n(nc_n), .group_b_noise_cut_n(nc_n), .ext_noise_cut_n(nc_n),
    .group_a_big_jitter_n(jit_n), .group_b_big_jitter_n(jit_n), .ext_big_jitter_n(jit_n),
    .cascade_open_drain_n(od_n), .rate_code(rate),
    .group_a_tx_out(tx_all[1:0]), .group_b_tx_out(tx_all[3:2]),
    .fifth_port_tx_out(tx_all[4]), .fifth_port_tx_oe, .dipulse_tx_pulse_n,
    .backplane_tx_pulse_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest
  );
  // verdict, reached from the tests or the watchdog
  task automatic end_of_test();
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // cycles per bit for a rate code
  function automatic int bit_cyc(input logic [2:0] r);
    return (r < 3'h5) ? (20 << (3'h4 - r)) : ((r == 3'h5) ? 10 : 5);
  endfunction
  // one access; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (20) @(posedge sys_clk);
    chk({tx_all, fifth_port_tx_oe, dipulse_tx_pulse_n, backplane_tx_pulse_n,
         avs_waitrequest}, 10'h00f, "reset pins");
    chk(avs_readdata, 32'h0000_0000, "reset data");
    rst_n <= 1'h1;
    repeat (5) @(posedge sys_clk);
  endtask
  // four-pulse frame on port p; en says whether direction may lock
  task automatic frame(input int p, input logic en, input int gl);
    int bc;
    logic [4:0] want;
    bc = bit_cyc(rate);
    falls = 0;
    fork
      hpio_media_model_inst.send(p, 4, bc, gl);
      begin
        // look while a regenerated pulse stands, so pulse style shows it
        if (en) begin
          @(negedge backplane_tx_pulse_n);
        end else begin
          repeat (bc + 8) @(posedge sys_clk);
        end
        @(posedge sys_clk);
        want = ~(5'h01 << p) & {5{en & (sty | !backplane_tx_pulse_n)}};
        want = want ^ {5{!ah}};
        chk(tx_all & mask, want & mask, "direction");
        if (!od_n) chk({tx_all[4], fifth_port_tx_oe}, {1'h0, en}, "drain on");
      end
    join
    repeat (12 * bc + 20) @(posedge sys_clk);
    chk(tx_all & mask, {5{!ah}} & mask, "release");
    if (!od_n) chk(fifth_port_tx_oe, 1'h0, "drain off");
    chk(falls, en ? (jit_n ? 4 : 3) : 0, "pulse count");
  endtask
  // stops a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    chk({tx_all, fifth_port_tx_oe, dipulse_tx_pulse_n}, 8'h03, "reset");
    rst_n <= 1'h1;
    repeat (5) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      {rate, row_port, inv, ah, sty, jit_n} <= rows[i];
      repeat (5) @(posedge sys_clk);
      frame(row_port, 1'h1, 0);
      bus(1'h0, hpio_pkg::REG_STATUS, 32'h0000_0000, q);
      chk(q[7:4], {1'h0, rate}, "rate latch");
    end
    // mid-run reset, then register space
    do_reset();
    bus(1'h0, hpio_pkg::REG_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "ctrl reset");
    bus(1'h1, 4'h8, 32'hffff_ffff, q);
    bus(1'h0, 4'h8, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "unmapped");
    bus(1'h1, hpio_pkg::REG_CTRL, 32'h0000_0001, q);
    bus(1'h0, hpio_pkg::REG_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0001, "ctrl rw");
    // inhibit keeps every port quiet
    frame(0, 1'h0, 0);
    bus(1'h1, hpio_pkg::REG_CTRL, 32'h0000_0000, q);
    // reserved rate never locks
    rate <= hpio_pkg::RATE_RSVD;
    repeat (5) @(posedge sys_clk);
    bus(1'h0, hpio_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(q[7], 1'h1, "reserved flag");
    frame(1, 1'h0, 0);
    // ringing is cut by the dead band, first pulse included
    rate <= hpio_pkg::RATE_2M5;
    jit_n <= 1'h0;
    nc_n <= 1'h0;
    repeat (5) @(posedge sys_clk);
    frame(3, 1'h1, 1);
    // open drain fifth port, active low
    od_n <= 1'h0;
    ah <= 1'h0;
    repeat (5) @(posedge sys_clk);
    frame(0, 1'h1, 0);
    end_of_test();
  end
endmodule
